/* File: core/lrcr_chan.v */
// Purpose: One colour channel result: exponent, mantissa, rolling counter and check code.
// Assumes: The conversion engine pulses conv_done for one cycle with a finished result.
// Notes:   The check code is computed from the incoming result and stored with it.
`timescale 1ns/1ns
`include "lrcr_defs.vh"

module lrcr_chan (
    // Clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // Conversion engine update
    input  wire        conv_done,
    input  wire [3:0]  conv_exp,
    input  wire [19:0] conv_mant,
    // Stored result words
    output wire [15:0] word_high,
    output wire [15:0] word_low,
    // Full-scale range of the stored exponent
    output reg         range_ok,
    output reg  [10:0] full_scale
);

    reg  [3:0]  exp_q;
    reg  [11:0] mant_high_q;
    reg  [7:0]  mant_low_q;
    reg  [3:0]  count_q;
    reg  [3:0]  check_q;
    wire [3:0]  check_d;
    wire        check_b3;
    wire        check_b2;
    wire        check_b1;
    wire        check_b0;
    wire [19:0] mant_join;

    // mantissa join
    // The 20-bit mantissa is the high part shifted up plus the low part.
    assign mant_join = {conv_mant[19:`LRCR_MANT_SHIFT], 8'h00} + {12'h000, conv_mant[7:0]};

    // Check bits are resolved from the top down so that each later bit can use earlier ones.
    // Separate nets keep the chain free of any bit reading its own vector.
    // check bit three
    assign check_b3 = mant_join[3] ^ mant_join[11] ^ mant_join[19];
    assign check_b2 = check_b3 ^ mant_join[3] ^ mant_join[7] ^ mant_join[11]
                      ^ mant_join[15] ^ mant_join[19] ^ conv_exp[3];
    assign check_b1 = check_b3 ^ mant_join[1] ^ mant_join[3] ^ mant_join[5]
                      ^ mant_join[7] ^ mant_join[9] ^ mant_join[11] ^ mant_join[13]
                      ^ mant_join[15] ^ mant_join[17] ^ mant_join[19]
                      ^ conv_exp[1] ^ conv_exp[3];
    assign check_b0 = (^conv_exp) ^ (^mant_join) ^ check_b3 ^ check_b2 ^ check_b1;
    assign check_d  = {check_b3, check_b2, check_b1, check_b0};

    always @(posedge core_clk) begin
        if (sys_rst) begin
            exp_q       <= 4'h0;
            mant_high_q <= 12'h000;
            mant_low_q  <= 8'h00;
            check_q     <= 4'h0;
        end else if (conv_done) begin
            exp_q       <= conv_exp;
            mant_high_q <= mant_join[19:8];
            mant_low_q  <= mant_join[7:0];
            check_q     <= check_d;
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            count_q <= `LRCR_RST_COUNT;
        end else if (conv_done) begin
            count_q <= count_q + 4'h1;
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            range_ok   <= 1'b1;
            full_scale <= `LRCR_FS_0;
        end else begin
            range_ok <= (exp_q <= `LRCR_EXP_MAX_RANGE);
            case (exp_q)
                4'h0: full_scale <= `LRCR_FS_0;
                4'h1: full_scale <= `LRCR_FS_1;
                4'h2: full_scale <= `LRCR_FS_2;
                4'h3: full_scale <= `LRCR_FS_3;
                4'h4: full_scale <= `LRCR_FS_4;
                4'h5: full_scale <= `LRCR_FS_5;
                4'h6: full_scale <= `LRCR_FS_6;
                default: full_scale <= `LRCR_FS_NONE;
            endcase
        end
    end

    assign word_high = {exp_q, mant_high_q};
    assign word_low  = {mant_low_q, count_q, check_q};

endmodule // lrcr_chan

/* File: core/lrcr_defs.vh */
// Purpose: Offsets, field positions and reset values of the light result register bank.
// Assumes: Word-wide register port, one 16-bit word for each offset.
// Notes:   Full-scale figures are in units of 100 lux.
`ifndef LRCR_DEFS_VH
`define LRCR_DEFS_VH

// Register offsets.
`define LRCR_OFS_CH2_RESULT_HIGH  8'h04
`define LRCR_OFS_CH2_RESULT_LOW   8'h05
`define LRCR_OFS_CH3_RESULT_HIGH  8'h06
`define LRCR_OFS_CH3_RESULT_LOW   8'h07
`define LRCR_OFS_LOW_THRESHOLD    8'h08

// Reset values.
`define LRCR_RST_RESULT           16'h0000
`define LRCR_RST_LOW_THRESHOLD    16'h0000
`define LRCR_RST_COUNT            4'h0

// Fields of the first word of a result pair and of the low threshold.
`define LRCR_EXP_MSB              15
`define LRCR_EXP_LSB              12
`define LRCR_MANT_HIGH_MSB        11
`define LRCR_MANT_HIGH_LSB        0

// Fields of the second word of a result pair.
`define LRCR_MANT_LOW_MSB         15
`define LRCR_MANT_LOW_LSB         8
`define LRCR_COUNT_MSB            7
`define LRCR_COUNT_LSB            4
`define LRCR_CHECK_MSB            3
`define LRCR_CHECK_LSB            0

// Mantissa split: twelve high bits shifted left by this amount.
`define LRCR_MANT_SHIFT           8

// Highest exponent code that names a full-scale range.
`define LRCR_EXP_MAX_RANGE        4'h6

// Full-scale range for exponent codes 0 to 6, in units of 100 lux.
`define LRCR_FS_0                 11'h016
`define LRCR_FS_1                 11'h02D
`define LRCR_FS_2                 11'h05A
`define LRCR_FS_3                 11'h0B4
`define LRCR_FS_4                 11'h168
`define LRCR_FS_5                 11'h2D0
`define LRCR_FS_6                 11'h5A0
`define LRCR_FS_NONE              11'h000

// Value returned for an unmapped offset.
`define LRCR_RD_UNMAPPED          16'h0000

`endif

/* File: core/lrcr_regs.v */
// Purpose: Result register bank of two colour channels and the low threshold register.
// Assumes: A word-wide register port driven by the serial host interface, synchronous inputs.
// Notes:   Reads answer one cycle after the strobe; a high-word read freezes the low word.
//
// Operation
// - Channel-2 first word bits 15:12 hold read-only range exponent.
// - First word bits 11:0 hold top twelve mantissa bits, reset zero.
// - Second word bits 15:8 hold low eight mantissa bits, reset zero.
// - Second word bits 7:4 count conversions, add one each, wrap.
// - Mantissa is high twelve bits shifted left eight plus low eight.
// - Check bit 0 is parity over exponent, mantissa and other check bits.
// - Check bit 1 is parity of bit 3, odd mantissa bits, exponent 1,3.
// - Check bit 2 is parity of bit 3, mantissa 3,7,11,15,19, exponent 3.
// - Check bit 3 is parity of mantissa bits 3, 11 and 19.
// - Channel-3 pair sits at offsets 6 and 7, same layout, reset zero.
// - Channel-2 low word sits at offset 5, high word at offset 4.
// - Offset 8 is read-write low threshold: exponent 15:12, result 11:0.
// - Exponent codes 0 to 6 give ranges doubling from 2.2 to 144 klux.
`timescale 1ns/1ns
`include "lrcr_defs.vh"

module lrcr_regs (
    // Clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // Host register port
    input  wire [7:0]  host_addr,
    input  wire        host_rd_en,
    input  wire        host_wr_en,
    input  wire [15:0] host_wdata,
    output reg  [15:0] host_rdata,
    output reg         host_rd_valid,
    output reg         host_addr_err,
    // Conversion engine, second channel
    input  wire        conv_done_second,
    input  wire [3:0]  range_exp_second,
    input  wire [19:0] mantissa_second,
    // Conversion engine, third channel
    input  wire        conv_done_third,
    input  wire [3:0]  range_exp_third,
    input  wire [19:0] mantissa_third,
    // Low threshold towards the comparator
    output reg  [3:0]  thr_low_exp,
    output reg  [11:0] thr_low_result,
    // Full-scale range of each stored result
    output wire        range_ok_second,
    output wire [10:0] full_scale_second,
    output wire        range_ok_third,
    output wire [10:0] full_scale_third
);

    wire [15:0] high_second;
    wire [15:0] low_second;
    wire [15:0] high_third;
    wire [15:0] low_third;

    reg  [15:0] low_threshold_q;
    reg  [15:0] snap_second_q;
    reg         snap_second_vld_q;
    reg  [15:0] snap_third_q;
    reg         snap_third_vld_q;
    reg  [15:0] rdata_d;
    reg         mapped_d;
    reg         wr_mapped_d;

    wire        hit_high_second;
    wire        hit_low_second;
    wire        hit_high_third;
    wire        hit_low_third;
    wire        hit_threshold;

    assign hit_high_second = (host_addr == `LRCR_OFS_CH2_RESULT_HIGH);
    assign hit_low_second  = (host_addr == `LRCR_OFS_CH2_RESULT_LOW);
    assign hit_high_third  = (host_addr == `LRCR_OFS_CH3_RESULT_HIGH);
    assign hit_low_third   = (host_addr == `LRCR_OFS_CH3_RESULT_LOW);
    assign hit_threshold   = (host_addr == `LRCR_OFS_LOW_THRESHOLD);

    // Second channel result.
    lrcr_chan u_chan_second (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .conv_done  (conv_done_second),
        .conv_exp   (range_exp_second),
        .conv_mant  (mantissa_second),
        .word_high  (high_second),
        .word_low   (low_second),
        .range_ok   (range_ok_second),
        .full_scale (full_scale_second)
    );

    // Third channel result.
    lrcr_chan u_chan_third (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .conv_done  (conv_done_third),
        .conv_exp   (range_exp_third),
        .conv_mant  (mantissa_third),
        .word_high  (high_third),
        .word_low   (low_third),
        .range_ok   (range_ok_third),
        .full_scale (full_scale_third)
    );

    always @(posedge core_clk) begin
        if (sys_rst) begin
            low_threshold_q <= `LRCR_RST_LOW_THRESHOLD;
        end else if (host_wr_en && hit_threshold) begin
            low_threshold_q <= host_wdata;
        end
    end

    // The comparator sees the threshold fields one cycle after they are stored.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            thr_low_exp    <= 4'h0;
            thr_low_result <= 12'h000;
        end else begin
            thr_low_exp    <= low_threshold_q[`LRCR_EXP_MSB:`LRCR_EXP_LSB];
            thr_low_result <= low_threshold_q[`LRCR_MANT_HIGH_MSB:`LRCR_MANT_HIGH_LSB];
        end
    end

    // Reading a high word freezes the matching low word, so a new conversion landing
    // between the two reads cannot pair one result's top bits with another's bottom bits.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            snap_second_q     <= `LRCR_RST_RESULT;
            snap_second_vld_q <= 1'b0;
        end else if (host_rd_en && hit_high_second) begin
            snap_second_q     <= low_second;
            snap_second_vld_q <= 1'b1;
        end else if (host_rd_en && hit_low_second) begin
            snap_second_vld_q <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            snap_third_q     <= `LRCR_RST_RESULT;
            snap_third_vld_q <= 1'b0;
        end else if (host_rd_en && hit_high_third) begin
            snap_third_q     <= low_third;
            snap_third_vld_q <= 1'b1;
        end else if (host_rd_en && hit_low_third) begin
            snap_third_vld_q <= 1'b0;
        end
    end

    // Read multiplexer.
    always @* begin
        rdata_d  = `LRCR_RD_UNMAPPED;
        mapped_d = 1'b1;
        case (host_addr)
            `LRCR_OFS_CH2_RESULT_HIGH: rdata_d = high_second;
            `LRCR_OFS_CH2_RESULT_LOW: begin
                if (snap_second_vld_q) begin
                    rdata_d = snap_second_q;
                end else begin
                    rdata_d = low_second;
                end
            end
            `LRCR_OFS_CH3_RESULT_HIGH: rdata_d = high_third;
            `LRCR_OFS_CH3_RESULT_LOW: begin
                if (snap_third_vld_q) begin
                    rdata_d = snap_third_q;
                end else begin
                    rdata_d = low_third;
                end
            end
            `LRCR_OFS_LOW_THRESHOLD: rdata_d = low_threshold_q;
            default: begin
                rdata_d  = `LRCR_RD_UNMAPPED;
                mapped_d = 1'b0;
            end
        endcase
    end

    // read-only writes dropped
    // Only the threshold offset accepts a write; result offsets are decoded but refused.
    always @* begin
        wr_mapped_d = hit_threshold | hit_high_second | hit_low_second
                      | hit_high_third | hit_low_third;
    end

    // Read answer and address error, both one cycle after the strobe.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            host_rdata    <= 16'h0000;
            host_rd_valid <= 1'b0;
            host_addr_err <= 1'b0;
        end else begin
            host_rd_valid <= host_rd_en;
            host_addr_err <= (host_rd_en & ~mapped_d) | (host_wr_en & ~wr_mapped_d);
            if (host_rd_en) begin
                host_rdata <= rdata_d;
            end
        end
    end

endmodule // lrcr_regs

/* File: tb/lrcr_host_model.sv */
// Purpose: Host that reads and writes register words.
// Assumes: Requests change at falling edges only.
// Notes:   Address shows its inverse between requests.
`timescale 1ns/1ns
module lrcr_host_model (
    input  wire         core_clk,
    input  wire  [15:0] host_rdata,
    input  wire         host_rd_valid,
    input  wire         host_addr_err,
    output logic [7:0]  host_addr  = 8'h00,
    output logic        host_rd_en = 1'b0,
    output logic        host_wr_en = 1'b0,
    output logic [15:0] host_wdata = 16'h0000
);
    task rd(input [7:0] a, output [15:0] d, output v, output e);
        @(negedge core_clk);
        host_addr = a;
        host_rd_en = 1'b1;
        @(negedge core_clk);
        host_rd_en = 1'b0;
        host_addr = ~a;
        d = host_rdata;
        v = host_rd_valid;
        e = host_addr_err;
    endtask

    task wr(input [7:0] a, input [15:0] d);
        @(negedge core_clk);
        host_addr = a;
        host_wdata = d;
        host_wr_en = 1'b1;
        @(negedge core_clk);
        host_wr_en = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
    endtask
endmodule // lrcr_host_model

/* File: tb/lrcr_regs_monitor.sv */
// Purpose: Port checks of the light result register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every instance by bind.
`timescale 1ns/1ns
module lrcr_regs_monitor (
    input wire        core_clk,
    input wire        sys_rst,
    input wire [7:0]  host_addr,
    input wire        host_rd_en,
    input wire        host_wr_en,
    input wire [15:0] host_wdata,
    input wire [15:0] host_rdata,
    input wire        host_rd_valid,
    input wire        host_addr_err,
    input wire        conv_done_second,
    input wire [3:0]  range_exp_second,
    input wire [19:0] mantissa_second,
    input wire        conv_done_third,
    input wire [3:0]  range_exp_third,
    input wire [19:0] mantissa_third,
    input wire [3:0]  thr_low_exp,
    input wire [11:0] thr_low_result,
    input wire [10:0] full_scale_second,
    input wire        range_ok_third,
    input wire [10:0] full_scale_third
);
    reg  [15:0] hi2_q;
    reg  [15:0] hi3_q;
    wire        mapped_w = host_addr >= 8'h04 && host_addr <= 8'h08;
    wire        wr8_w    = host_wr_en && host_addr == 8'h08;

    // Shadow of the first word that each channel should show.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            hi2_q <= 16'h0000;
            hi3_q <= 16'h0000;
        end else begin
            if (conv_done_second)
                hi2_q <= {range_exp_second, mantissa_second[19:8]};
            if (conv_done_third)
                hi3_q <= {range_exp_third, mantissa_third[19:8]};
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_rd_pulse;
        host_rd_valid == $past(host_rd_en);
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read answer timing wrong");

    property p_unmapped;
        host_rd_en && !mapped_w |=> host_addr_err && host_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");

    property p_wr_err;
        host_wr_en && !host_rd_en |=> host_addr_err == !$past(mapped_w);
    endproperty
    a_wr_err: assert property (p_wr_err) else $error("write error flag wrong");

    property p_thr_wr;
        wr8_w |=> ##1 {thr_low_exp, thr_low_result} == $past(host_wdata, 2);
    endproperty
    a_thr_wr: assert property (p_thr_wr) else $error("threshold not written");

    property p_thr_hold;
        !wr8_w ##1 !wr8_w |=> $stable({thr_low_exp, thr_low_result});
    endproperty
    a_thr_hold: assert property (p_thr_hold) else $error("threshold changed unasked");

    property p_hi2;
        host_rd_en && host_addr == 8'h04 && !conv_done_second |=> host_rdata == hi2_q;
    endproperty
    a_hi2: assert property (p_hi2) else $error("second channel high word wrong");

    property p_hi3;
        host_rd_en && host_addr == 8'h06 && !conv_done_third |=> host_rdata == hi3_q;
    endproperty
    a_hi3: assert property (p_hi3) else $error("third channel high word wrong");

    property p_fs_max;
        conv_done_second && range_exp_second == 4'h6 ##1 !conv_done_second
            |=> full_scale_second == 11'h5A0;
    endproperty
    a_fs_max: assert property (p_fs_max) else $error("top range wrong");

    property p_fs_bad;
        conv_done_third && range_exp_third > 4'h6 ##1 !conv_done_third
            |=> !range_ok_third && full_scale_third == 11'h000;
    endproperty
    a_fs_bad: assert property (p_fs_bad) else $error("bad exponent not flagged");
endmodule // lrcr_regs_monitor

bind lrcr_regs lrcr_regs_monitor mon_u (.core_clk, .sys_rst, .host_addr, .host_rd_en,
    .host_wr_en, .host_wdata, .host_rdata, .host_rd_valid, .host_addr_err,
    .conv_done_second, .range_exp_second, .mantissa_second, .conv_done_third,
    .range_exp_third, .mantissa_third, .thr_low_exp, .thr_low_result,
    .full_scale_second, .range_ok_third, .full_scale_third);

/* File: tb/test_light_result_crc_regs.sv */
// Purpose: Self-checking bench of the light result register bank.
// Assumes: Host model drives the register port.
// Notes:   Expected words are rebuilt from the values fed in.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_light_result_crc_regs;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    wire  [7:0]  host_addr;
    wire         host_rd_en;
    wire         host_wr_en;
    wire  [15:0] host_wdata;
    wire  [15:0] host_rdata;
    wire         host_rd_valid;
    wire         host_addr_err;
    logic        cd2 = 1'b0;
    logic        cd3 = 1'b0;
    logic [3:0]  e2  = 4'h0;
    logic [3:0]  e3  = 4'h0;
    logic [19:0] m2  = 20'h00000;
    logic [19:0] m3  = 20'h00000;
    wire  [3:0]  thr_exp;
    wire  [11:0] thr_res;
    wire  [10:0] fs2;
    wire  [10:0] fs3;
    wire         ok2;
    wire         ok3;
    logic [3:0]  le [0:1] = '{4'h0, 4'h0};
    logic [3:0]  lc [0:1] = '{4'h0, 4'h0};
    logic [19:0] lm [0:1] = '{20'h00000, 20'h00000};
    int          err_total = 0;
    int          n_tests   = 0;
    int          cyc       = 0;

    always #25 core_clk = ~core_clk;

    lrcr_regs dut_u (.core_clk, .sys_rst, .host_addr, .host_rd_en, .host_wr_en,
        .host_wdata, .host_rdata, .host_rd_valid, .host_addr_err,
        .conv_done_second(cd2), .range_exp_second(e2), .mantissa_second(m2),
        .conv_done_third(cd3), .range_exp_third(e3), .mantissa_third(m3),
        .thr_low_exp(thr_exp), .thr_low_result(thr_res),
        .range_ok_second(ok2), .full_scale_second(fs2),
        .range_ok_third(ok3), .full_scale_third(fs3));

    lrcr_host_model hm_u (.core_clk, .host_rdata, .host_rd_valid, .host_addr_err,
        .host_addr, .host_rd_en, .host_wr_en, .host_wdata);

    function automatic [3:0] crc(input [3:0] e, input [19:0] r);
        logic x3, x2, x1;
        x3 = r[3] ^ r[11] ^ r[19];
        x2 = x3 ^ r[3] ^ r[7] ^ r[11] ^ r[15] ^ r[19] ^ e[3];
        x1 = x3 ^ (^(r & 20'hAAAAA)) ^ e[1] ^ e[3];
        return {x3, x2, x1, (^e) ^ (^r) ^ x3 ^ x2 ^ x1};
    endfunction

    task conv(input int ch, input [3:0] e, input [19:0] m);
        @(negedge core_clk);
        cd2 = (ch == 0);
        cd3 = (ch == 1);
        {e2, m2} = ch ? {e2, m2} : {e, m};
        {e3, m3} = ch ? {e, m} : {e3, m3};
        le[ch] = e;
        lm[ch] = m;
        lc[ch] = lc[ch] + 4'h1;
        @(negedge core_clk);
        cd2 = 1'b0;
        cd3 = 1'b0;
    endtask

    task chk(input int ch);
        logic [15:0] d;
        logic        v, er;
        hm_u.rd(8'(4 + 2 * ch), d, v, er);
        `CHK({v, d}, {1'b1, le[ch], lm[ch][19:8]})
        hm_u.rd(8'(5 + 2 * ch), d, v, er);
        `CHK(d, {lm[ch][7:0], lc[ch], crc(le[ch], lm[ch])})
    endtask

    task t_reset;
        logic [15:0] d;
        logic        v, er;
        for (int a = 4; a <= 8; a++) begin
            hm_u.rd(8'(a), d, v, er);
            `CHK({v, er, d}, {2'b10, 16'h0000})
        end
        hm_u.rd(8'h03, d, v, er);
        `CHK({v, er, d}, {2'b11, 16'h0000})
    endtask

    task t_results;
        conv(0, 4'h5, 20'hABCDE);
        chk(0);
        conv(1, 4'hA, 20'h13579);
        chk(1);
        for (int i = 0; i < 17; i++) begin
            conv(0, 4'(i), 20'(i * 32'h1B3D7));
            chk(0);
        end
    endtask

    task t_range;
        logic [10:0] fs_tab [0:7];
        fs_tab = '{11'h016, 11'h02D, 11'h05A, 11'h0B4, 11'h168, 11'h2D0, 11'h5A0, 11'h000};
        for (int i = 0; i < 8; i++) begin
            conv(0, 4'(i), 20'(i * 32'h2468B));
            @(negedge core_clk);
            `CHK({ok2, fs2}, {1'(i < 7), fs_tab[i]})
        end
    endtask

    task t_thr;
        logic [15:0] d;
        logic        v, er;
        hm_u.wr(8'h08, 16'hA5C3);
        hm_u.rd(8'h08, d, v, er);
        `CHK({v, d}, {1'b1, 16'hA5C3})
        `CHK({thr_exp, thr_res}, 16'hA5C3)
        for (int a = 4; a <= 7; a++)
            hm_u.wr(8'(a), 16'hFFFF);
        chk(0);
        chk(1);
        hm_u.wr(8'h09, 16'h1234);
        `CHK(host_addr_err, 1'b1)
    endtask

    task t_pair;
        logic [15:0] d, old_low;
        logic        v, er;
        conv(0, 4'h3, 20'h2C0F1);
        old_low = {lm[0][7:0], lc[0], crc(le[0], lm[0])};
        hm_u.rd(8'h04, d, v, er);
        conv(0, 4'h4, 20'h9E37A);
        hm_u.rd(8'h05, d, v, er);
        `CHK(d, old_low)
        hm_u.rd(8'h05, d, v, er);
        `CHK(d, {lm[0][7:0], lc[0], crc(le[0], lm[0])})
    endtask

    task t_mid_rst;
        logic [15:0] d;
        logic        v, er;
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        le = '{4'h0, 4'h0};
        lm = '{20'h00000, 20'h00000};
        lc = '{4'h0, 4'h0};
        chk(0);
        chk(1);
        hm_u.rd(8'h08, d, v, er);
        `CHK(d, 16'h0000)
        `CHK({ok2, fs2}, {1'b1, 11'h016})
    endtask

    task give_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            give_verdict;
        end
    end

    initial begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset;
        t_results;
        t_range;
        t_thr;
        t_pair;
        t_mid_rst;
        give_verdict;
    end
endmodule // test_light_result_crc_regs
